// >>> rtl/cfb_pkg.sv
// Constants and carrier types for the configuration fuse bank.
package cfb_pkg;

  localparam int unsigned CFB_WORDS = 9;

  // Table access addresses in configuration space.
  localparam logic [21:0] CFB_ADDR_WDT     = 22'h30_0003;
  localparam logic [21:0] CFB_ADDR_PIN     = 22'h30_0005;
  localparam logic [21:0] CFB_ADDR_CORE    = 22'h30_0006;
  localparam logic [21:0] CFB_ADDR_CP_BLK  = 22'h30_0008;
  localparam logic [21:0] CFB_ADDR_CP_REG  = 22'h30_0009;
  localparam logic [21:0] CFB_ADDR_WP_BLK  = 22'h30_000A;
  localparam logic [21:0] CFB_ADDR_WP_REG  = 22'h30_000B;
  localparam logic [21:0] CFB_ADDR_RP_BLK  = 22'h30_000C;
  localparam logic [21:0] CFB_ADDR_RP_BOOT = 22'h30_000D;
  localparam logic [21:0] CFB_ADDR_ID_LOW  = 22'h3F_FFFE;
  localparam logic [21:0] CFB_ADDR_ID_HIGH = 22'h3F_FFFF;

  // Word index order of the fuse cell array; protect words come last.
  typedef enum logic [3:0] {
    W_WDT, W_PIN, W_CORE, W_CP_BLK, W_CP_REG,
    W_WP_BLK, W_WP_REG, W_RP_BLK, W_RP_BOOT
  } cfb_word_t;

  // Implemented bits and unprogrammed value of each word.
  localparam logic [7:0] CFB_MASK [CFB_WORDS] = '{
    8'h1F, 8'h8F, 8'hC5, 8'h0F, 8'hC0, 8'h0F, 8'hE0, 8'h0F, 8'h40};
  localparam logic [7:0] CFB_DEFAULT [CFB_WORDS] = '{
    8'h1F, 8'h8B, 8'h85, 8'h0F, 8'hC0, 8'h0F, 8'hE0, 8'h0F, 8'h40};

  // Field positions.
  localparam int unsigned CFB_BIT_WDT_EN  = 0;
  localparam int unsigned CFB_PS_LSB      = 1;
  localparam int unsigned CFB_PS_MSB      = 4;
  localparam int unsigned CFB_BIT_RST_PIN = 7;
  localparam int unsigned CFB_BIT_FAST    = 3;
  localparam int unsigned CFB_BIT_LP_OSC  = 2;
  localparam int unsigned CFB_BIT_ANALOG  = 1;
  localparam int unsigned CFB_BIT_CCP     = 0;
  localparam int unsigned CFB_BIT_DEBUG   = 7;
  localparam int unsigned CFB_BIT_EXT_ISA = 6;
  localparam int unsigned CFB_BIT_SUPPLY  = 2;
  localparam int unsigned CFB_BIT_STACK   = 0;
  localparam int unsigned CFB_BIT_EEPROM  = 7;
  localparam int unsigned CFB_BIT_BOOT    = 6;
  localparam int unsigned CFB_BIT_CFG_WP  = 5;
  localparam int unsigned CFB_BLK_MSB     = 3;

  // Idle levels of the synchronised pins {oscillator stable, reset pin, programming}.
  localparam logic [2:0] CFB_PIN_IDLE = 3'h2;

  // Self-timed long write duration.
  localparam int unsigned CFB_LONG_WRITE_NS = 2000;
  localparam int unsigned CFB_CLK_NS        = 20;
  localparam logic [7:0]  CFB_WRITE_CYCLES  =
    8'((CFB_LONG_WRITE_NS + CFB_CLK_NS - 1) / CFB_CLK_NS);
  localparam logic [7:0]  CFB_CNT_ONE = 8'h01;
  localparam logic [7:0]  CFB_CNT_ZERO = 8'h00;

  typedef enum logic {ST_IDLE, ST_WRITE} cfb_state_t;

  // Decoded static settings.
  typedef struct packed {
    logic [3:0] postscale_sel;
    logic       hard_enable;
    logic       reset_pin_enable;
    logic       fast_osc_start;
    logic       low_power_osc;
    logic       analog_default;
    logic       capture_route;
    logic       debug_off;
    logic       extended_isa;
    logic       single_supply;
    logic       stack_reset;
  } cfb_settings_t;

  // Protection fuses, all active low as stored.
  typedef struct packed {
    logic [3:0] code_n;
    logic       eeprom_code_n;
    logic       boot_code_n;
    logic [3:0] write_n;
    logic       eeprom_write_n;
    logic       boot_write_n;
    logic       config_write_n;
    logic [3:0] read_n;
    logic       boot_read_n;
  } cfb_protect_t;

endpackage

// >>> rtl/cfb_fuse_bank.sv
// Configuration fuse bank with table access, long writes and decoded settings.
//
// Contract
// - Postscale field bits 4..1 selects watchdog ratio one to two-power-code.
// - Hard enable fuse set forces watchdog on; else soft enable decides.
// - Reset pin fuse set makes shared pin master reset, input disabled.
// - Fast start fuse releases clock at once; else wait oscillator stable.
// - Bit 2 selects low-power or higher-power secondary timer oscillator.
// - Bit 1 sets reset value of five port analog-select bits.
// - Bit 0 routes second capture unit to port C1 or port B3.
// - Debug fuse zero enables debugger and dedicates two port B pins.
// - Bit 6 enables extended instruction set and indexed addressing.
// - Single-supply programming fuse changes only in high-voltage programming mode.
// - Stack fault fuse set lets stack full or underflow reset device.
// - Four block code-protect fuses in bits 3..0, zero protects.
// - All protect fuses default one and can only be cleared.
// - EEPROM code protect bit 7, boot code protect bit 6.
// - Four block write-protect fuses in bits 3..0, zero protects.
// - EEPROM write protect bit 7, boot write protect bit 6.
// - Config write protect bit 5; read always, written only in programming.
// - Four block table-read-protect fuses; zero blocks reads from other blocks.
// - Boot table-read-protect bit 6; zero refuses foreign reads of boot.
// - First ident word read-only: low part code and revision.
// - Second ident word read-only: eight high part code bits.
// - Unimplemented bits read as zero.
// - Words reached by table access only, byte writes self-timed.
`timescale 1ns/1ns
module cfb_fuse_bank
  import cfb_pkg::*;
#(
  // Arbitrary identification values, not those of any real part.
  parameter logic [2:0] PART_CODE_LOW    = 3'h2,
  parameter logic [4:0] SILICON_REVISION = 5'h01,
  parameter logic [7:0] PART_CODE_HIGH   = 8'h5A
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Table access path
  input  wire logic [21:0]   tbl_addr,
  input  wire logic          tbl_rd_req,
  input  wire logic          tbl_wr_req,
  input  wire logic [7:0]    tbl_wr_data,
  output logic      [7:0]    tbl_rd_data,
  output logic               tbl_rd_valid,
  output logic               tbl_wr_busy,
  output logic               tbl_wr_done,
  // Pins
  input  wire logic          prog_mode_pin,
  input  wire logic          master_reset_pin_n,
  // Other on-chip units
  input  wire logic          watchdog_soft_enable,
  input  wire logic          osc_stable_in,
  input  wire logic          stack_fault,
  // Decoded controls
  output cfb_settings_t      settings,
  output cfb_protect_t       protect,
  output logic      [15:0]   watchdog_postscale_ratio,
  output logic               watchdog_run,
  output logic               master_reset_req,
  output logic               port_e_pin3_in,
  output logic               sys_clock_release,
  output logic      [4:0]    port_analog_select_init,
  output logic               capture_on_port_c1,
  output logic               capture_on_port_b3,
  output logic               debugger_enable,
  output logic               stack_fault_reset
);

  localparam int WR_DONE_DLY = int'(CFB_WRITE_CYCLES) + 1;
  localparam int WR_BUSY_MIN = 8;

  // Address decode shared by the read and write paths.
  function automatic logic [4:0] word_lookup(input logic [21:0] a);
    unique case (a)
      CFB_ADDR_WDT:     word_lookup = {1'b1, W_WDT};
      CFB_ADDR_PIN:     word_lookup = {1'b1, W_PIN};
      CFB_ADDR_CORE:    word_lookup = {1'b1, W_CORE};
      CFB_ADDR_CP_BLK:  word_lookup = {1'b1, W_CP_BLK};
      CFB_ADDR_CP_REG:  word_lookup = {1'b1, W_CP_REG};
      CFB_ADDR_WP_BLK:  word_lookup = {1'b1, W_WP_BLK};
      CFB_ADDR_WP_REG:  word_lookup = {1'b1, W_WP_REG};
      CFB_ADDR_RP_BLK:  word_lookup = {1'b1, W_RP_BLK};
      CFB_ADDR_RP_BOOT: word_lookup = {1'b1, W_RP_BOOT};
      default:          word_lookup = {1'b0, W_WDT};
    endcase
  endfunction

  // Ratio as a power of two of the postscale code.
  function automatic logic [15:0] ps_ratio(input logic [3:0] code);
    ps_ratio = 16'h0001 << code;
  endfunction

  // Value a committed byte leaves in a word.
  function automatic logic [7:0] merge_byte(input cfb_word_t w,
                                            input logic [7:0] old,
                                            input logic [7:0] data,
                                            input logic       prog);
    logic [7:0] v;
    v = data & CFB_MASK[w];
    if (w >= W_CP_BLK) begin
      v = v & old;
    end
    if (w == W_CORE && !prog) begin
      v[CFB_BIT_SUPPLY] = old[CFB_BIT_SUPPLY];
    end
    if (w == W_WP_REG && !prog) begin
      v[CFB_BIT_CFG_WP] = old[CFB_BIT_CFG_WP];
    end
    merge_byte = v;
  endfunction

  // Fuse cells, write engine and pin synchronisers.
  logic [7:0]    fuse_cell_reg [CFB_WORDS];
  cfb_state_t    state_reg;
  logic [7:0]    wr_cnt_reg;
  cfb_word_t     wr_word_reg;
  logic [7:0]    wr_data_reg;
  logic          wr_done_reg;
  logic [7:0]    rd_data_reg;
  logic          rd_valid_reg;
  logic [2:0]    sync1_reg;
  logic [2:0]    sync2_reg;
  logic [2:0]    sync3_reg;
  logic [2:0]    pin_filt_reg;
  logic          load_pend_reg;
  cfb_settings_t settings_reg;
  cfb_protect_t  protect_reg;
  logic [4:0]    rd_hit;
  logic [4:0]    wr_hit;
  logic          prog_mode;
  logic          wr_take;
  logic [7:0]    commit_val;

  // Three-stage synchronisers; a change counts once stages two and three agree.
  // Stages start at the pin idle levels, so no false edge follows reset.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_reg <= CFB_PIN_IDLE;
      sync2_reg <= CFB_PIN_IDLE;
      sync3_reg <= CFB_PIN_IDLE;
    end else begin
      sync1_reg <= {osc_stable_in, master_reset_pin_n, prog_mode_pin};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // The reset pin idles high, so its filtered copy starts high.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_filt_reg <= CFB_PIN_IDLE;
    end else begin
      pin_filt_reg <= (~(sync2_reg ^ sync3_reg) & sync3_reg)
                    | ((sync2_reg ^ sync3_reg) & pin_filt_reg);
    end
  end

  assign prog_mode = pin_filt_reg[0];
  assign rd_hit    = word_lookup(tbl_addr);
  assign wr_hit    = word_lookup(tbl_addr);

  // A write is taken when idle, mapped, and the words are not locked.
  // Locked words still accept writes from the programmer.
  assign wr_take = tbl_wr_req && state_reg == ST_IDLE && wr_hit[4]
                && (prog_mode || fuse_cell_reg[W_WP_REG][CFB_BIT_CFG_WP]);

  assign commit_val = merge_byte(wr_word_reg, fuse_cell_reg[wr_word_reg],
                                 wr_data_reg, prog_mode);

  // Long write sequencer: one byte per request, self-timed.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg   <= ST_IDLE;
      wr_cnt_reg  <= CFB_CNT_ZERO;
      wr_word_reg <= W_WDT;
      wr_data_reg <= 8'h00;
      wr_done_reg <= 1'b0;
    end else begin
      wr_done_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (wr_take) begin
            state_reg   <= ST_WRITE;
            wr_cnt_reg  <= CFB_WRITE_CYCLES - CFB_CNT_ONE;
            wr_word_reg <= cfb_word_t'(wr_hit[3:0]);
            wr_data_reg <= tbl_wr_data;
          end
        end
        ST_WRITE: begin
          if (wr_cnt_reg == CFB_CNT_ZERO) begin
            state_reg   <= ST_IDLE;
            wr_done_reg <= 1'b1;
          end else begin
            wr_cnt_reg <= wr_cnt_reg - CFB_CNT_ONE;
          end
        end
      endcase
    end
  end

  // Cells start erased; the reset here models a blank part and is the only
  // way to bring protect fuses back to one.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < CFB_WORDS; i++) begin
        fuse_cell_reg[i] <= CFB_DEFAULT[i];
      end
    end else if (state_reg == ST_WRITE && wr_cnt_reg == CFB_CNT_ZERO) begin
      fuse_cell_reg[wr_word_reg] <= commit_val;
    end
  end

  // Read port: one cycle latency, unmapped and unimplemented bits as zero.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data_reg  <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= tbl_rd_req;
      if (tbl_rd_req) begin
        if (tbl_addr == CFB_ADDR_ID_LOW) begin
          rd_data_reg <= {PART_CODE_LOW, SILICON_REVISION};
        end else if (tbl_addr == CFB_ADDR_ID_HIGH) begin
          rd_data_reg <= PART_CODE_HIGH;
        end else if (rd_hit[4]) begin
          rd_data_reg <= fuse_cell_reg[rd_hit[3:0]] & CFB_MASK[rd_hit[3:0]];
        end else begin
          rd_data_reg <= 8'h00;
        end
      end
    end
  end

  // Settings are captured once after reset release so that a later fuse
  // write cannot shift a unit's behaviour under running code.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      load_pend_reg <= 1'b1;
      settings_reg  <= '0;
      protect_reg   <= '0;
    end else if (load_pend_reg) begin
      load_pend_reg <= 1'b0;
      settings_reg.postscale_sel    <=
        fuse_cell_reg[W_WDT][CFB_PS_MSB:CFB_PS_LSB];
      settings_reg.hard_enable      <= fuse_cell_reg[W_WDT][CFB_BIT_WDT_EN];
      settings_reg.reset_pin_enable <= fuse_cell_reg[W_PIN][CFB_BIT_RST_PIN];
      settings_reg.fast_osc_start   <= fuse_cell_reg[W_PIN][CFB_BIT_FAST];
      settings_reg.low_power_osc    <= fuse_cell_reg[W_PIN][CFB_BIT_LP_OSC];
      settings_reg.analog_default   <= fuse_cell_reg[W_PIN][CFB_BIT_ANALOG];
      settings_reg.capture_route    <= fuse_cell_reg[W_PIN][CFB_BIT_CCP];
      settings_reg.debug_off        <= fuse_cell_reg[W_CORE][CFB_BIT_DEBUG];
      settings_reg.extended_isa     <= fuse_cell_reg[W_CORE][CFB_BIT_EXT_ISA];
      settings_reg.single_supply    <= fuse_cell_reg[W_CORE][CFB_BIT_SUPPLY];
      settings_reg.stack_reset      <= fuse_cell_reg[W_CORE][CFB_BIT_STACK];
      protect_reg.code_n         <= fuse_cell_reg[W_CP_BLK][CFB_BLK_MSB:0];
      protect_reg.eeprom_code_n  <= fuse_cell_reg[W_CP_REG][CFB_BIT_EEPROM];
      protect_reg.boot_code_n    <= fuse_cell_reg[W_CP_REG][CFB_BIT_BOOT];
      protect_reg.write_n        <= fuse_cell_reg[W_WP_BLK][CFB_BLK_MSB:0];
      protect_reg.eeprom_write_n <= fuse_cell_reg[W_WP_REG][CFB_BIT_EEPROM];
      protect_reg.boot_write_n   <= fuse_cell_reg[W_WP_REG][CFB_BIT_BOOT];
      protect_reg.config_write_n <= fuse_cell_reg[W_WP_REG][CFB_BIT_CFG_WP];
      protect_reg.read_n         <= fuse_cell_reg[W_RP_BLK][CFB_BLK_MSB:0];
      protect_reg.boot_read_n    <= fuse_cell_reg[W_RP_BOOT][CFB_BIT_BOOT];
    end
  end

  // Table path outputs.
  assign tbl_rd_data  = rd_data_reg;
  assign tbl_rd_valid = rd_valid_reg;
  assign tbl_wr_busy  = state_reg == ST_WRITE;
  assign tbl_wr_done  = wr_done_reg;

  // Decoded controls for the other units.
  assign settings                 = settings_reg;
  assign protect                  = protect_reg;
  assign watchdog_postscale_ratio = ps_ratio(settings_reg.postscale_sel);
  assign watchdog_run = settings_reg.hard_enable | watchdog_soft_enable;
  assign master_reset_req  = settings_reg.reset_pin_enable & ~pin_filt_reg[1];
  assign port_e_pin3_in    = ~settings_reg.reset_pin_enable & pin_filt_reg[1];
  assign sys_clock_release = settings_reg.fast_osc_start | pin_filt_reg[2];
  assign port_analog_select_init = {5{settings_reg.analog_default}};
  assign capture_on_port_c1 = settings_reg.capture_route;
  assign capture_on_port_b3 = ~settings_reg.capture_route;
  assign debugger_enable    = ~settings_reg.debug_off;
  assign stack_fault_reset  = settings_reg.stack_reset & stack_fault;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // A taken write holds busy, then finishes at the fixed long write time.
  sequence wr_start_s;
    wr_take;
  endsequence
  sequence wr_hold_s;
    tbl_wr_busy [*8];
  endsequence

  long_write_a: assert property (wr_start_s |=> wr_hold_s)
    else $error("long write did not hold busy");
  write_time_a: assert property (wr_start_s |-> ##WR_DONE_DLY tbl_wr_done)
    else $error("long write did not finish on time");

  supply_guard_a: assert property (
    tbl_wr_done && !$past(prog_mode) && $past(wr_word_reg) == W_CORE
      |-> fuse_cell_reg[W_CORE][CFB_BIT_SUPPLY]
          == $past(fuse_cell_reg[W_CORE][CFB_BIT_SUPPLY]))
    else $error("single supply fuse changed outside programming mode");

  clear_only_a: assert property (
    (fuse_cell_reg[W_CP_BLK] & ~$past(fuse_cell_reg[W_CP_BLK])) == 8'h00
    && (fuse_cell_reg[W_WP_REG] & ~$past(fuse_cell_reg[W_WP_REG])) == 8'h00
    && (fuse_cell_reg[W_RP_BOOT] & ~$past(fuse_cell_reg[W_RP_BOOT])) == 8'h00)
    else $error("protect fuse went back to one");

  cfg_lock_a: assert property (
    tbl_wr_req && !tbl_wr_busy && !prog_mode
      && !fuse_cell_reg[W_WP_REG][CFB_BIT_CFG_WP] |=> !tbl_wr_busy)
    else $error("locked configuration accepted a write");

  ident_read_a: assert property (
    tbl_rd_req && tbl_addr == CFB_ADDR_ID_LOW
      |=> tbl_rd_data == {PART_CODE_LOW, SILICON_REVISION})
    else $error("ident low word wrong");

  unimpl_zero_a: assert property (
    tbl_rd_req && rd_hit[4]
      |=> (tbl_rd_data & ~CFB_MASK[$past(rd_hit[3:0])]) == 8'h00)
    else $error("unimplemented bit read as one");

  ratio_decode_a: assert property (
    !load_pend_reg && $past(load_pend_reg)
      |-> watchdog_postscale_ratio
          == (16'h0001 << $past(fuse_cell_reg[W_WDT][CFB_PS_MSB:CFB_PS_LSB]))
          && $countones(watchdog_postscale_ratio) == 1)
    else $error("postscale ratio mismatch");

  wdt_force_a: assert property (
    settings.hard_enable |-> watchdog_run)
    else $error("hard enabled watchdog not running");

  static_set_a: assert property (
    !load_pend_reg && !$past(load_pend_reg) |-> $stable(settings_reg))
    else $error("settings changed after load");

  // Paired decodes stay exclusive, forcing fuses take effect, the programming filter waits for its stages, and handshakes keep their timing.
  pin_route_a: assert property (
    !(master_reset_req && port_e_pin3_in))
    else $error("reset pin and input both active");

  clock_release_a: assert property (
    settings.fast_osc_start |-> sys_clock_release)
    else $error("fast start did not release the clock");

  capture_route_a: assert property (
    capture_on_port_c1 != capture_on_port_b3)
    else $error("capture unit routed to both or no pins");

  stack_reset_a: assert property (
    stack_fault && settings.stack_reset |-> stack_fault_reset)
    else $error("stack fault did not request reset");

  prog_filter_a: assert property (
    $changed(prog_mode) |-> $past(sync2_reg[0]) == $past(sync3_reg[0]))
    else $error("programming mode changed before its stages agreed");

  read_answer_a: assert property (
    tbl_rd_req |=> tbl_rd_valid)
    else $error("read got no valid pulse");

  done_pulse_a: assert property (
    tbl_wr_done |=> !tbl_wr_done)
    else $error("write done stood longer than one cycle");

endmodule

// >>> verification/cfb_prog_model.sv
// Programmer and table access master model driving the request side of the fuse bank.
`timescale 1ns/1ns
module cfb_prog_model (
  // Clock
  input  wire logic        clk,
  // Requests towards the bank
  output logic      [21:0] tbl_addr,
  output logic             tbl_rd_req,
  output logic             tbl_wr_req,
  output logic      [7:0]  tbl_wr_data,
  output logic             prog_mode_pin,
  // Answers from the bank
  input  wire logic [7:0]  tbl_rd_data,
  input  wire logic        tbl_rd_valid,
  input  wire logic        tbl_wr_busy,
  input  wire logic        tbl_wr_done
);

  // Idle state; the data lines carry a pattern so a stale byte is never mistaken for a write.
  initial begin
    tbl_addr      = 22'h00_0000;
    tbl_rd_req    = 1'b0;
    tbl_wr_req    = 1'b0;
    tbl_wr_data   = 8'hA5;
    prog_mode_pin = 1'b0;
  end

  // One table read: request for one edge, answer taken just after it, then one idle edge
  // so that a following call never lowers and raises the request in one time step.
  task automatic rd(input logic [21:0] a, output logic [7:0] d, output logic ok);
    tbl_addr   = a;
    tbl_rd_req = 1'b1;
    @(posedge clk) #1;
    tbl_rd_req = 1'b0;
    ok         = (tbl_rd_valid === 1'b1);
    d          = tbl_rd_data;
    @(posedge clk) #1;
  endtask

  // One byte write, then a bounded wait for the self-timed commit.
  task automatic wr(input logic [21:0] a, input logic [7:0] d, output logic taken,
                    output logic ok);
    int n;
    tbl_addr    = a;
    tbl_wr_data = d;
    tbl_wr_req  = 1'b1;
    @(posedge clk) #1;
    tbl_wr_req  = 1'b0;
    tbl_wr_data = ~d;
    taken       = (tbl_wr_busy === 1'b1);
    ok          = !taken;
    for (n = 0; n < 120 && !ok; n++) begin
      @(posedge clk) #1;
      ok = (tbl_wr_done === 1'b1);
    end
    @(posedge clk) #1;
  endtask

  // Enter or leave high-voltage programming; the pin filter needs a few edges.
  task automatic set_prog(input logic m);
    prog_mode_pin = m;
    repeat (5) @(posedge clk);
    #1;
  endtask

endmodule

// >>> verification/cfb_fuse_bank_tb_top.sv
// Self-checking testbench for the configuration fuse bank.
`timescale 1ns/1ns
module cfb_fuse_bank_tb_top;
  import cfb_pkg::*;

  // Arbitrary identification values, unrelated to any real part.
  localparam logic [2:0] TB_CODE_LOW  = 3'h5;
  localparam logic [4:0] TB_REVISION  = 5'h0B;
  localparam logic [7:0] TB_CODE_HIGH = 8'h3C;

  logic          clk;
  logic          reset;
  logic [21:0]   tbl_addr;
  logic          tbl_rd_req, tbl_wr_req, tbl_rd_valid, tbl_wr_busy, tbl_wr_done;
  logic [7:0]    tbl_wr_data, tbl_rd_data;
  logic          prog_mode_pin, master_reset_pin_n, watchdog_soft_enable;
  logic          osc_stable_in, stack_fault;
  cfb_settings_t settings;
  cfb_protect_t  protect;
  logic [15:0]   watchdog_postscale_ratio;
  logic          watchdog_run, master_reset_req, port_e_pin3_in, sys_clock_release;
  logic [4:0]    port_analog_select_init;
  logic          capture_on_port_c1, capture_on_port_b3, debugger_enable, stack_fault_reset;
  int            err_count, n_tests, i;
  logic [21:0]   adr_tab [9];
  logic [7:0]    dft_tab [9];

  cfb_fuse_bank #(.PART_CODE_LOW(TB_CODE_LOW), .SILICON_REVISION(TB_REVISION),
                  .PART_CODE_HIGH(TB_CODE_HIGH)) u_cfb_fuse_bank (
    .clk(clk), .reset(reset), .tbl_addr(tbl_addr), .tbl_rd_req(tbl_rd_req),
    .tbl_wr_req(tbl_wr_req), .tbl_wr_data(tbl_wr_data), .tbl_rd_data(tbl_rd_data),
    .tbl_rd_valid(tbl_rd_valid), .tbl_wr_busy(tbl_wr_busy), .tbl_wr_done(tbl_wr_done),
    .prog_mode_pin(prog_mode_pin), .master_reset_pin_n(master_reset_pin_n),
    .watchdog_soft_enable(watchdog_soft_enable), .osc_stable_in(osc_stable_in),
    .stack_fault(stack_fault), .settings(settings), .protect(protect),
    .watchdog_postscale_ratio(watchdog_postscale_ratio), .watchdog_run(watchdog_run),
    .master_reset_req(master_reset_req), .port_e_pin3_in(port_e_pin3_in),
    .sys_clock_release(sys_clock_release), .port_analog_select_init(port_analog_select_init),
    .capture_on_port_c1(capture_on_port_c1), .capture_on_port_b3(capture_on_port_b3),
    .debugger_enable(debugger_enable), .stack_fault_reset(stack_fault_reset));

  cfb_prog_model u_cfb_prog_model (
    .clk(clk), .tbl_addr(tbl_addr), .tbl_rd_req(tbl_rd_req), .tbl_wr_req(tbl_wr_req),
    .tbl_wr_data(tbl_wr_data), .prog_mode_pin(prog_mode_pin), .tbl_rd_data(tbl_rd_data),
    .tbl_rd_valid(tbl_rd_valid), .tbl_wr_busy(tbl_wr_busy), .tbl_wr_done(tbl_wr_done));

  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Compare one value; case inequality keeps unknowns from passing.
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Let n edges pass and land just after the last one.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Read one word and check the answer and its valid pulse.
  task automatic rchk(input logic [21:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_cfb_prog_model.rd(a, d, ok);
    chk({23'h0, ok}, 24'h00_0001);
    chk({16'h0, d}, {16'h0, exp});
  endtask

  // Write one byte and check whether it was taken and committed in time.
  task automatic wchk(input logic [21:0] a, input logic [7:0] d, input logic exp_taken);
    logic taken;
    logic ok;
    u_cfb_prog_model.wr(a, d, taken, ok);
    chk({23'h0, taken}, {23'h0, exp_taken});
    chk({23'h0, ok}, 24'h00_0001);
  endtask

  // Summary line, verdict and end of run.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs far fewer cycles than this.
  initial begin
    repeat (6000) @(posedge clk);
    err_count++;
    conclude();
  end

  // Main sequence.
  initial begin
    adr_tab = '{CFB_ADDR_WDT, CFB_ADDR_PIN, CFB_ADDR_CORE, CFB_ADDR_CP_BLK, CFB_ADDR_CP_REG,
                CFB_ADDR_WP_BLK, CFB_ADDR_WP_REG, CFB_ADDR_RP_BLK, CFB_ADDR_RP_BOOT};
    dft_tab = '{8'h1F, 8'h8B, 8'h85, 8'h0F, 8'hC0, 8'h0F, 8'hE0, 8'h0F, 8'h40};
    err_count = 0;
    n_tests = 0;
    reset = 1'b1;
    master_reset_pin_n = 1'b1;
    watchdog_soft_enable = 1'b0;
    osc_stable_in = 1'b0;
    stack_fault = 1'b0;
    cyc(16);
    reset = 1'b0;
    cyc(6);
    for (i = 0; i < 9; i++) rchk(adr_tab[i], dft_tab[i]);
    rchk(CFB_ADDR_ID_LOW, {TB_CODE_LOW, TB_REVISION});
    rchk(CFB_ADDR_ID_HIGH, TB_CODE_HIGH);
    rchk(22'h30_0004, 8'h00);
    // Decoded outputs of an erased part.
    chk(watchdog_postscale_ratio, 24'h00_8000);
    chk(watchdog_run, 24'h00_0001);
    chk({master_reset_req, port_e_pin3_in}, 24'h00_0000);
    chk(sys_clock_release, 24'h00_0001);
    chk(settings.low_power_osc, 24'h00_0000);
    chk(port_analog_select_init, 24'h00_001F);
    chk({capture_on_port_c1, capture_on_port_b3}, 24'h00_0002);
    chk(debugger_enable, 24'h00_0000);
    chk(settings.extended_isa, 24'h00_0000);
    chk(protect, 24'h03_FFFF);
    chk(stack_fault_reset, 24'h00_0000);
    stack_fault = 1'b1;
    master_reset_pin_n = 1'b0;
    cyc(5);
    chk(stack_fault_reset, 24'h00_0001);
    chk(master_reset_req, 24'h00_0001);
    stack_fault = 1'b0;
    master_reset_pin_n = 1'b1;
    cyc(5);
    // Writes in normal execution.
    wchk(CFB_ADDR_WDT, 8'hE6, 1'b1);
    rchk(CFB_ADDR_WDT, 8'h06);
    chk(watchdog_postscale_ratio, 24'h00_8000);
    wchk(CFB_ADDR_WP_BLK, 8'h05, 1'b1);
    wchk(CFB_ADDR_WP_BLK, 8'h0F, 1'b1);
    rchk(CFB_ADDR_WP_BLK, 8'h05);
    wchk(CFB_ADDR_CORE, 8'h81, 1'b1);
    rchk(CFB_ADDR_CORE, 8'h85);
    wchk(CFB_ADDR_WP_REG, 8'h00, 1'b1);
    rchk(CFB_ADDR_WP_REG, 8'h20);
    wchk(CFB_ADDR_ID_LOW, 8'h00, 1'b0);
    // Writes under the programmer.
    u_cfb_prog_model.set_prog(1'b1);
    wchk(CFB_ADDR_CORE, 8'h81, 1'b1);
    rchk(CFB_ADDR_CORE, 8'h81);
    wchk(CFB_ADDR_WP_REG, 8'h00, 1'b1);
    rchk(CFB_ADDR_WP_REG, 8'h00);
    wchk(CFB_ADDR_CP_REG, 8'h40, 1'b1);
    rchk(CFB_ADDR_CP_REG, 8'h40);
    wchk(CFB_ADDR_CP_BLK, 8'h0C, 1'b1);
    rchk(CFB_ADDR_CP_BLK, 8'h0C);
    wchk(CFB_ADDR_RP_BLK, 8'h0A, 1'b1);
    rchk(CFB_ADDR_RP_BLK, 8'h0A);
    wchk(CFB_ADDR_RP_BOOT, 8'h00, 1'b1);
    rchk(CFB_ADDR_RP_BOOT, 8'h00);
    chk(protect, 24'h03_FFFF);
    u_cfb_prog_model.set_prog(1'b0);
    // Configuration locked and programmer gone: a fuse write is refused.
    wchk(CFB_ADDR_PIN, 8'h00, 1'b0);
    rchk(CFB_ADDR_PIN, 8'h8B);
    // A second reset reloads the erased cells and the decoded outputs.
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    cyc(6);
    rchk(CFB_ADDR_CORE, 8'h85);
    chk(protect, 24'h03_FFFF);
    chk(watchdog_postscale_ratio, 24'h00_8000);
    conclude();
  end

endmodule
